// ### inc/ccs_pkg.sv
`default_nettype none
//==========================================================
// shared constants for the command-check supervisor
package ccs_pkg;

	// time base
	localparam int CCS_CLK_PERIOD_NS = 10;
	localparam int CCS_TB_UNIT_NS    = 100000;
	localparam int CCS_TICK_CYC      = (CCS_TB_UNIT_NS + CCS_CLK_PERIOD_NS - 1)
	                                   / CCS_CLK_PERIOD_NS;

	// window length field, in time base units
	localparam int CCS_WIN_W = 16;

	// synchronised pin vector layout
	localparam int CCS_NUM_PINS = 4;
	localparam int CCS_PIN_CMD  = 0;
	localparam int CCS_PIN_ENG  = 1;
	localparam int CCS_PIN_REL  = 2;
	localparam int CCS_PIN_ACK  = 3;

	// values after reset
	localparam logic [CCS_NUM_PINS-1:0] CCS_RST_PINS  = 4'h0;
	localparam logic                    CCS_RST_PHYS  = 1'h0;
	localparam logic                    CCS_RST_FAULT = 1'h0;

	typedef enum logic [2:0]
	{
		ST_OFF,
		ST_ENG_WIN,
		ST_ENG_HOLD,
		ST_REL_WIN,
		ST_REL_HOLD
	} ccs_state_e;

endpackage : ccs_pkg
`default_nettype wire

// ### core/ccs_window_timer.sv
`timescale 1ns/10ps
`default_nettype none
module ccs_window_timer
	import ccs_pkg::*;
#(
	parameter int TICK_CYCLES = CCS_TICK_CYC,
	parameter int WIN_W       = CCS_WIN_W
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             start,
	input  wire logic             stop,
	input  wire logic [WIN_W-1:0] length,
	output logic                  expire,
	output logic                  running
);

	localparam int             PW       = $clog2(TICK_CYCLES + 1);
	localparam logic [PW-1:0]  PRE_LAST = PW'(TICK_CYCLES - 1);
	localparam logic [WIN_W-1:0] ONE    = WIN_W'(1);

	logic [PW-1:0]    pre_reg;
	logic [PW-1:0]    pre_next;
	logic [WIN_W-1:0] cnt_reg;
	logic [WIN_W-1:0] cnt_next;
	logic             run_reg;
	logic             run_next;
	logic             exp_reg;
	logic             exp_next;

	//==========================================================
	// window countdown
	// a zero length behaves as one unit, so a window always has a body
	always_comb
	begin
		pre_next = pre_reg;
		cnt_next = cnt_reg;
		run_next = run_reg;
		exp_next = 1'h0;
		if (start)
		begin
			run_next = 1'h1;
			pre_next = '0;
			cnt_next = length;
		end
		else if (stop)
			run_next = 1'h0;
		else if (run_reg)
		begin
			if (pre_reg == PRE_LAST)
			begin
				pre_next = '0;
				if (cnt_reg <= ONE)
				begin
					run_next = 1'h0;
					exp_next = 1'h1;
				end
				else
					cnt_next = cnt_reg - ONE;
			end
			else
				pre_next = pre_reg + PW'(1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pre_reg <= '0;
			cnt_reg <= '0;
			run_reg <= 1'h0;
			exp_reg <= 1'h0;
		end
		else
		begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
			run_reg <= run_next;
			exp_reg <= exp_next;
		end
	end

	assign expire  = exp_reg;
	assign running = run_reg;

endmodule : ccs_window_timer
`default_nettype wire

// ### core/ccs_supervisor.sv
// Operation
// - v1: command rise sets output, starts window
// - v1: check seen in window, no fault
// - v1: no check by window end, fault A
// - v1: check drops, command high, fault B
// - v1: ack rise with check high clears
// - v1: command fall clears output and fault
// - v2: command rise sets output, engage window
// - v2: engage check seen, no fault
// - v2: no engage check, fault A
// - v2: engage check drops, fault B
// - v2 engage: ack rise with engage check high, or command change, clears
// - v2: command fall clears output, release window
// - v2: release check seen, no fault
// - v2: no release check, fault A
// - v2: release check drops, fault B
// - v2 release: ack rise with release check high, or command change, clears
// - two window lengths, 0.1 ms units
`timescale 1ns/10ps
`default_nettype none
module ccs_supervisor
	import ccs_pkg::*;
#(
	parameter int TICK_CYCLES = CCS_TICK_CYC,
	parameter int WIN_W       = CCS_WIN_W
)
(
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             cmdIn,
	input  wire logic             engage_check_in,
	input  wire logic             release_check_in,
	input  wire logic             faultAckIn,
	input  wire logic             variantTwo,
	input  wire logic [WIN_W-1:0] engage_window,
	input  wire logic [WIN_W-1:0] release_window,
	output logic                  physOut,
	output logic                  auxFaultOut,
	output logic                  faultTypeA,
	output logic                  faultTypeB
);

	//==========================================================
	// pin synchronisers and edge detection
	logic [CCS_NUM_PINS-1:0] pins;
	logic [CCS_NUM_PINS-1:0] syncMeta_reg;
	logic [CCS_NUM_PINS-1:0] syncOut_reg;
	logic [CCS_NUM_PINS-1:0] prev_reg;
	logic [CCS_NUM_PINS-1:0] rise;
	logic [CCS_NUM_PINS-1:0] fall;

	assign pins[CCS_PIN_CMD] = cmdIn;
	assign pins[CCS_PIN_ENG] = engage_check_in;
	assign pins[CCS_PIN_REL] = release_check_in;
	assign pins[CCS_PIN_ACK] = faultAckIn;

	genvar gi;
	generate
		for (gi = 0; gi < CCS_NUM_PINS; gi++)
		begin : g_sync
			always_ff @(posedge ref_clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					syncMeta_reg[gi] <= CCS_RST_PINS[gi];
					syncOut_reg[gi]  <= CCS_RST_PINS[gi];
					prev_reg[gi]     <= CCS_RST_PINS[gi];
				end
				else
				begin
					syncMeta_reg[gi] <= pins[gi];
					syncOut_reg[gi]  <= syncMeta_reg[gi];
					prev_reg[gi]     <= syncOut_reg[gi];
				end
			end
			assign rise[gi] = syncOut_reg[gi] & ~prev_reg[gi];
			assign fall[gi] = ~syncOut_reg[gi] & prev_reg[gi];
		end
	endgenerate

	logic cmdRise;
	logic cmdFall;
	logic engLvl;
	logic engFall;
	logic relLvl;
	logic relFall;
	logic ackRise;

	assign cmdRise = rise[CCS_PIN_CMD];
	assign cmdFall = fall[CCS_PIN_CMD];
	assign engLvl  = syncOut_reg[CCS_PIN_ENG];
	assign engFall = fall[CCS_PIN_ENG];
	assign relLvl  = syncOut_reg[CCS_PIN_REL];
	assign relFall = fall[CCS_PIN_REL];
	assign ackRise = rise[CCS_PIN_ACK];

	//==========================================================
	// window timer
	logic             tmrStart;
	logic             tmrStop;
	logic [WIN_W-1:0] tmrLen;
	logic             tmrExpire;

	ccs_window_timer #(
		.TICK_CYCLES (TICK_CYCLES),
		.WIN_W       (WIN_W)
	) u_timer (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.start   (tmrStart),
		.stop    (tmrStop),
		.length  (tmrLen),
		.expire  (tmrExpire),
		.running ()
	);

	//==========================================================
	// supervision state
	ccs_state_e state_reg;
	ccs_state_e state_next;
	logic       physOut_reg;
	logic       physOut_next;
	logic       fault_reg;
	logic       fault_next;
	logic       typeA_reg;
	logic       typeA_next;
	logic       typeB_reg;
	logic       typeB_next;
	logic       seen_reg;
	logic       seen_next;
	logic       setA;
	logic       setB;
	logic       ackChk;
	logic       chkFall;
	logic       inRelease;

	assign inRelease = (state_reg == ST_REL_WIN) || (state_reg == ST_REL_HOLD);
	assign ackChk    = inRelease ? relLvl : engLvl;
	assign chkFall   = inRelease ? relFall : engFall;

	always_comb
	begin
		state_next   = state_reg;
		physOut_next = physOut_reg;
		fault_next   = fault_reg;
		typeA_next   = typeA_reg;
		typeB_next   = typeB_reg;
		seen_next    = seen_reg;
		tmrStart     = 1'h0;
		tmrStop      = 1'h0;
		tmrLen       = engage_window;
		setA         = 1'h0;
		setB         = 1'h0;
		// command edges outrank any check event in the same cycle
		if (cmdRise)
		begin
			state_next   = ST_ENG_WIN;
			physOut_next = 1'h1;
			tmrStart     = 1'h1;
			seen_next    = 1'h0;
			fault_next   = 1'h0;
			typeA_next   = 1'h0;
			typeB_next   = 1'h0;
		end
		else if (cmdFall)
		begin
			physOut_next = 1'h0;
			fault_next   = 1'h0;
			typeA_next   = 1'h0;
			typeB_next   = 1'h0;
			seen_next    = 1'h0;
			if (variantTwo)
			begin
				state_next = ST_REL_WIN;
				tmrStart   = 1'h1;
				tmrLen     = release_window;
			end
			else
			begin
				state_next = ST_OFF;
				tmrStop    = 1'h1;
			end
		end
		else
		begin
			case (state_reg)
				ST_ENG_WIN,
				ST_REL_WIN:
				begin
					if (ackChk)
						seen_next = 1'h1;
					if (chkFall)
						setB = 1'h1;
					if (tmrExpire)
					begin
						state_next = inRelease ? ST_REL_HOLD : ST_ENG_HOLD;
						if (!seen_reg && !ackChk)
							setA = 1'h1;
					end
				end
				ST_ENG_HOLD,
				ST_REL_HOLD:
				begin
					if (chkFall)
						setB = 1'h1;
				end
				// idle waits here too, nothing to watch
				default:
				begin
					state_next = ST_OFF;
				end
			endcase
			// sticky, a new fault wins over ack
			if (setA || setB)
			begin
				fault_next = 1'h1;
				typeA_next = typeA_reg | setA;
				typeB_next = typeB_reg | setB;
			end
			else if (ackRise && ackChk)
			begin
				fault_next = 1'h0;
				typeA_next = 1'h0;
				typeB_next = 1'h0;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg   <= ST_OFF;
			physOut_reg <= CCS_RST_PHYS;
			fault_reg   <= CCS_RST_FAULT;
			typeA_reg   <= CCS_RST_FAULT;
			typeB_reg   <= CCS_RST_FAULT;
			seen_reg    <= 1'h0;
		end
		else
		begin
			state_reg   <= state_next;
			physOut_reg <= physOut_next;
			fault_reg   <= fault_next;
			typeA_reg   <= typeA_next;
			typeB_reg   <= typeB_next;
			seen_reg    <= seen_next;
		end
	end

	assign physOut     = physOut_reg;
	assign auxFaultOut = fault_reg;
	assign faultTypeA  = typeA_reg;
	assign faultTypeB  = typeB_reg;

	//==========================================================
	// assertions
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence sQuiet;
		!cmdRise && !cmdFall;
	endsequence
	sequence sEngExpireUnseen;
		state_reg == ST_ENG_WIN && tmrExpire && !seen_reg && !engLvl;
	endsequence
	sequence sRelExpireUnseen;
		state_reg == ST_REL_WIN && tmrExpire && !seen_reg && !relLvl;
	endsequence

	AST_ENGAGE_START: assert property (
		cmdRise |=> physOut_reg && state_reg == ST_ENG_WIN && !fault_reg)
		else $error("engage start not taken");
	AST_ENGAGE_OK: assert property (
		(state_reg == ST_ENG_WIN && tmrExpire && seen_reg && !fault_reg
		 && !engFall) and sQuiet |=> !fault_reg)
		else $error("fault raised despite confirmation");
	AST_ENGAGE_TIMEOUT: assert property (
		sEngExpireUnseen and sQuiet |=> fault_reg && typeA_reg)
		else $error("missing engage timeout fault");
	AST_ENGAGE_DROP: assert property (
		(engFall && (state_reg == ST_ENG_WIN || state_reg == ST_ENG_HOLD))
		and sQuiet |=> fault_reg && typeB_reg)
		else $error("missing engage drop-out fault");
	AST_ACK_CLEAR: assert property (
		(ackRise && ackChk && !setA && !setB) and sQuiet |=> !fault_reg)
		else $error("acknowledge did not clear fault");
	AST_V1_FALL: assert property (
		cmdFall && !variantTwo |=> !physOut_reg && !fault_reg
		&& state_reg == ST_OFF)
		else $error("variant 1 fall not cleared");
	AST_V2_FALL: assert property (
		cmdFall && variantTwo |=> !physOut_reg && state_reg == ST_REL_WIN)
		else $error("release window not started");
	AST_RELEASE_TIMEOUT: assert property (
		sRelExpireUnseen and sQuiet |=> fault_reg && typeA_reg
		##1 fault_reg || $past(ackRise) || $past(cmdRise) || $past(cmdFall))
		else $error("missing release timeout fault");
	AST_RELEASE_DROP: assert property (
		(relFall && inRelease) and sQuiet |=> fault_reg && typeB_reg)
		else $error("missing release drop-out fault");
	AST_FAULT_STICKY: assert property (
		fault_reg && !ackRise && !cmdRise && !cmdFall |=> fault_reg)
		else $error("fault dropped without clearing event");
	AST_EDGE_PULSE: assert property (
		cmdRise |=> !cmdRise)
		else $error("command edge longer than one cycle");

endmodule : ccs_supervisor
`default_nettype wire

// ### tb/ccs_field_model.sv
`timescale 1ns/10ps
`default_nettype none
//==========================================================
// actuator with engage and release sensors
module ccs_field_model
(
	input  wire logic ref_clk,
	input  wire logic rst_n,
	input  wire logic physOut,
	input  wire logic engOk,
	input  wire logic relOk,
	input  wire logic engDrop,
	input  wire logic relDrop,
	input  wire logic slowAns,
	output logic      engage_check_in,
	output logic      release_check_in
);
	logic [3:0] engCnt_reg, engCnt_next, relCnt_reg, relCnt_next, dly;
	logic       engGoal, relGoal, engDiff, relDiff;

	// sensors follow the actuator after a travel delay
	always_comb
	begin
		dly         = slowAns ? 4'h6 : 4'h1;
		engGoal     = physOut & engOk & ~engDrop;
		relGoal     = ~physOut & relOk & ~relDrop;
		engDiff     = engGoal != engage_check_in;
		relDiff     = relGoal != release_check_in;
		engCnt_next = engDiff ? engCnt_reg + 4'h1 : 4'h0;
		relCnt_next = relDiff ? relCnt_reg + 4'h1 : 4'h0;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			engCnt_reg       <= 4'h0;
			relCnt_reg       <= 4'h0;
			engage_check_in  <= 1'h0;
			release_check_in <= 1'h0;
		end
		else
		begin
			engCnt_reg <= engCnt_next;
			relCnt_reg <= relCnt_next;
			if (engDiff && engCnt_reg == dly)
				engage_check_in <= engGoal;
			if (relDiff && relCnt_reg == dly)
				release_check_in <= relGoal;
		end
	end
endmodule : ccs_field_model
`default_nettype wire

// ### tb/test_command_check_supervisor.sv
`timescale 1ns/10ps
`default_nettype none
module test_command_check_supervisor
	import ccs_pkg::*;
;
	localparam int T  = 4;
	localparam int NE = 3;
	localparam int NR = 2;
	logic ref_clk, rst_n, cmdIn, faultAckIn, variantTwo;
	logic engOk, relOk, engDrop, relDrop, slowAns;
	logic engage_check_in, release_check_in;
	logic physOut, auxFaultOut, faultTypeA, faultTypeB;
	int   error_cnt, comparisons, n, m;

	ccs_supervisor #(.TICK_CYCLES(T), .WIN_W(CCS_WIN_W)) u_dut
	(
		.ref_clk(ref_clk), .rst_n(rst_n), .cmdIn(cmdIn),
		.engage_check_in(engage_check_in), .release_check_in(release_check_in),
		.faultAckIn(faultAckIn), .variantTwo(variantTwo),
		.engage_window(16'(NE)), .release_window(16'(NR)),
		.physOut(physOut), .auxFaultOut(auxFaultOut),
		.faultTypeA(faultTypeA), .faultTypeB(faultTypeB)
	);

	ccs_field_model u_field
	(
		.ref_clk(ref_clk), .rst_n(rst_n), .physOut(physOut),
		.engOk(engOk), .relOk(relOk), .engDrop(engDrop), .relDrop(relDrop),
		.slowAns(slowAns), .engage_check_in(engage_check_in),
		.release_check_in(release_check_in)
	);

	//==========================================================
	// helpers
	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int k);
		repeat (k) @(negedge ref_clk);
	endtask : cyc

	// counts falling edges until the chosen output reaches v
	task automatic wait_on(input int aux, input int v, output int k);
		k = 0;
		while (((aux != 0 ? auxFaultOut : physOut) !== 1'(v)) && k < 200)
		begin
			@(negedge ref_clk);
			k++;
		end
		if (k == 200)
		begin
			error_cnt++;
			end_of_test();
		end
	endtask : wait_on

	task automatic ack();
		faultAckIn = 1'h1;
		cyc(3);
		faultAckIn = 1'h0;
		cyc(1);
	endtask : ack

	//==========================================================
	// scenarios
	task automatic t_v1_ok();
		variantTwo = 1'h0;
		engOk = 1'h1;
		cmdIn = 1'h1;
		wait_on(0, 1, n);
		chk(n, 3);
		cyc(20);
		chk(auxFaultOut, 0);
		cmdIn = 1'h0;
		wait_on(0, 0, n);
		chk(n, 3);
		cyc(6);
		$display("test v1_ok done");
	endtask : t_v1_ok

	task automatic t_v1_timeout();
		engOk = 1'h0;
		cmdIn = 1'h1;
		wait_on(1, 1, n);
		chk(n, 4 + NE * T);
		chk(faultTypeA, 1);
		// check still low, so the acknowledge must be refused
		ack();
		cyc(10);
		chk(auxFaultOut, 1);
		cmdIn = 1'h0;
		wait_on(1, 0, n);
		chk(n, 3);
		chk(physOut, 0);
		cyc(6);
		$display("test v1_timeout done");
	endtask : t_v1_timeout

	task automatic t_v1_drop();
		engOk = 1'h1;
		cmdIn = 1'h1;
		cyc(20);
		engDrop = 1'h1;
		wait_on(1, 1, n);
		chk(faultTypeB, 1);
		chk(faultTypeA, 0);
		engDrop = 1'h0;
		cyc(8);
		chk(auxFaultOut, 1);
		ack();
		chk(auxFaultOut, 0);
		cmdIn = 1'h0;
		cyc(8);
		$display("test v1_drop done");
	endtask : t_v1_drop

	task automatic t_v2_eng();
		variantTwo = 1'h1;
		slowAns = 1'h1;
		relOk = 1'h1;
		cmdIn = 1'h1;
		wait_on(0, 1, n);
		chk(n, 3);
		cyc(20);
		chk(auxFaultOut, 0);
		engDrop = 1'h1;
		wait_on(1, 1, n);
		chk(faultTypeB, 1);
		engDrop = 1'h0;
		cyc(12);
		chk(auxFaultOut, 1);
		ack();
		chk(auxFaultOut, 0);
		// slow answer would miss the shorter release window
		slowAns = 1'h0;
		cmdIn = 1'h0;
		wait_on(0, 0, n);
		chk(n, 3);
		cyc(20);
		chk(auxFaultOut, 0);
		$display("test v2_eng done");
	endtask : t_v2_eng

	task automatic t_v2_rel();
		engOk = 1'h0;
		cmdIn = 1'h1;
		wait_on(1, 1, n);
		chk(n, 4 + NE * T);
		chk(faultTypeA, 1);
		relOk = 1'h0;
		cmdIn = 1'h0;
		wait_on(1, 0, n);
		chk(n, 3);
		wait_on(1, 1, m);
		chk(n + m, 4 + NR * T);
		chk(faultTypeA, 1);
		engOk = 1'h1;
		relOk = 1'h1;
		cmdIn = 1'h1;
		wait_on(1, 0, n);
		chk(n, 3);
		cyc(20);
		cmdIn = 1'h0;
		cyc(15);
		relDrop = 1'h1;
		wait_on(1, 1, n);
		chk(faultTypeB, 1);
		relDrop = 1'h0;
		cyc(6);
		ack();
		chk(auxFaultOut, 0);
		$display("test v2_rel done");
	endtask : t_v2_rel

	//==========================================================
	// clock and main sequence
	initial
	begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end

	initial
	begin
		error_cnt = 0;
		comparisons = 0;
		rst_n = 1'h0;
		cmdIn = 1'h0;
		faultAckIn = 1'h0;
		variantTwo = 1'h0;
		engOk = 1'h0;
		relOk = 1'h0;
		engDrop = 1'h0;
		relDrop = 1'h0;
		slowAns = 1'h0;
		cyc(2);
		rst_n = 1'h1;
		cyc(2);
		t_v1_ok();
		t_v1_timeout();
		t_v1_drop();
		t_v2_eng();
		t_v2_rel();
		end_of_test();
	end
endmodule : test_command_check_supervisor
`default_nettype wire
